/* File: testbench.sv */
// self-checking bench for the video link switch configuration block
`timescale 1ns/1ps
module testbench;
  import vls_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i, cfg_rst_n_i, addr_pin_i, wr_stb, rd_stb, ack, hiz, ton, cur, sen, ssel;
  logic [6:0] dev, dev_addr, own;
  logic [7:0] reg_addr, wr_data, rdat, tdis, eq;
  logic [3:0] sel, pe;
  logic [7:0] m [0:7];
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed;
  assign dev = {6'h24, addr_pin_i};
  always #50 sys_clk_i = ~sys_clk_i;
  vls_top #(.PULSE_CYC(20)) dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cfg_rst_n_i(cfg_rst_n_i),
    .addr_pin_i(addr_pin_i), .dev_addr_i(dev_addr), .wr_stb_i(wr_stb), .rd_stb_i(rd_stb),
    .reg_addr_i(reg_addr), .wr_data_i(wr_data), .own_addr_o(own), .rd_ack_o(ack),
    .rd_data_o(rdat), .fast_source_select_o(sel), .fast_out_hiz_o(hiz),
    .input_term_dis_o(tdis), .input_eq_level_o(eq), .output_term_on_o(ton),
    .output_current_level_o(cur), .output_preemph_o(pe), .side_enable_o(sen),
    .side_source_select_o(ssel));
  vls_host_model host (.sys_clk_i(sys_clk_i), .dev_addr_o(dev_addr), .wr_stb_o(wr_stb),
    .rd_stb_o(rd_stb), .reg_addr_o(reg_addr), .wr_data_o(wr_data));
  // ----
  // helpers
  // ----
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic mdl_reset();
    m = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  endtask
  task automatic settle();
    repeat (UPD_DLY_CYC + 6) @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
    host.access(1'b1, dev, ra, wd);
    m[ra[2:0]] = (ra < 8'h06) ? (wd & REG_MASK[ra]) : 8'h00;
  endtask
  task automatic rd(input logic [7:0] ra);
    host.access(1'b0, dev, ra, 8'h00);
    chk("read ack", 8'h01, {7'h00, ack});
    chk("read data", m[ra[2:0]], rdat);
  endtask
  task automatic chk_all();
    chk("fast select", {4'h0, {4{m[0][0]}}}, {4'h0, sel});
    chk("fast hiz", {7'h00, ~m[0][6]}, {7'h00, hiz});
    chk("input term off", {8{m[3][0]}}, tdis);
    chk("eq level", m[4], eq);
    chk("output term", {7'h00, m[5][0]}, {7'h00, ton});
    chk("current", {7'h00, m[5][1]}, {7'h00, cur});
    chk("preemph", {4'h0, 4'h1 << m[5][3:2]}, {4'h0, pe});
    chk("side enable", {7'h00, m[1][6]}, {7'h00, sen});
    chk("side select", {7'h00, m[1][0]}, {7'h00, ssel});
  endtask
  // run takes about 1000 cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      stop_test();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    seed = 32'hBB27;
    addr_pin_i = 1'($random(seed));
    sys_rst_i = 1'b1;
    cfg_rst_n_i = 1'b1;
    mdl_reset();
    repeat (8) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    settle();
    chk("own address", {1'b0, 6'h24, addr_pin_i}, {1'b0, own});
    chk_all();
    for (int i = 0; i < 8; i++) begin
      rd(8'(i));
    end
    host.access(1'b1, dev ^ 7'h01, 8'h00, 8'h41);
    settle();
    chk_all();
    $display("test reset and addressing done");
    wr(8'h02, 8'($random(seed)));
    wr(8'h04, 8'($random(seed)));
    wr(8'h03, 8'hFF);
    wr(8'h01, 8'h01);
    wr(8'h07, 8'hFF);
    settle();
    chk_all();
    for (int i = 0; i < 4; i++) begin
      // odd steps drop internal termination and halve the current
      wr(8'h05, 8'(i << 2) | ((i % 2) ? 8'h02 : 8'h01));
      settle();
      chk_all();
    end
    wr(8'h00, 8'h00);
    wr(8'h03, 8'h00);
    settle();
    chk_all();
    for (int i = 0; i < 8; i++) begin
      rd(8'(i));
    end
    wr(8'h00, 8'h40);
    settle();
    chk_all();
    $display("test settings done");
    wr(8'h00, 8'h41);
    repeat (2) @(negedge sys_clk_i);
    chk("switch to B", 8'h0F, {4'h0, sel});
    repeat (3) @(negedge sys_clk_i);
    chk("term pulse", m[2], tdis);
    repeat (15) @(negedge sys_clk_i);
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h40);
    repeat (21) @(negedge sys_clk_i);
    chk("term pulse end", 8'h00, tdis);
    repeat (14) @(negedge sys_clk_i);
    chk("held select", 8'h0F, {4'h0, sel});
    chk("held hiz", 8'h00, {7'h00, hiz});
    repeat (10) @(negedge sys_clk_i);
    chk("latest select", 8'h00, {4'h0, sel});
    settle();
    chk_all();
    rd(8'h00);
    $display("test update window done");
    cfg_rst_n_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    cfg_rst_n_i = 1'b1;
    mdl_reset();
    repeat (4) @(negedge sys_clk_i);
    wr(8'h00, 8'h41);
    repeat (5) @(negedge sys_clk_i);
    chk("select after reset", 8'h00, {4'h0, sel});
    settle();
    chk_all();
    rd(8'h00);
    $display("test reset pin done");
    stop_test();
  end
endmodule

/* File: vls_host_model.sv */
// host model issuing decoded register accesses to the block
`timescale 1ns/1ps
module vls_host_model (
  // clock
  input wire logic sys_clk_i,
  // access
  output logic [6:0] dev_addr_o,
  output logic wr_stb_o,
  output logic rd_stb_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] wr_data_o
);
  initial begin
    dev_addr_o = 7'h00;
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    reg_addr_o = 8'h00;
    wr_data_o = 8'h00;
  end
  // one-cycle strobe; released lines show the inverse
  task automatic access(input logic wr, input logic [6:0] da, input logic [7:0] ra,
                        input logic [7:0] wd);
    @(negedge sys_clk_i);
    dev_addr_o = da;
    reg_addr_o = ra;
    wr_data_o = wd;
    wr_stb_o = wr;
    rd_stb_o = ~wr;
    @(negedge sys_clk_i);
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    dev_addr_o = ~da;
    reg_addr_o = ~ra;
    wr_data_o = ~wd;
  endtask
endmodule

/* File: vls_pkg.sv */
// constants for the video link switch configuration block
package vls_pkg;
  // ----------------------------------------
  // slave address
  // ----------------------------------------
  localparam logic [5:0] SLV_ADDR_HI = 6'h24;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam int NUM_REGS = 6;
  localparam logic [7:0] REG_FAST_MODES = 8'h00;
  localparam logic [7:0] REG_SIDE_MODES = 8'h01;
  localparam logic [7:0] REG_TERM_PULSE = 8'h02;
  localparam logic [7:0] REG_RX_SET = 8'h03;
  localparam logic [7:0] REG_INPUT_EQ_LEVEL = 8'h04;
  localparam logic [7:0] REG_TX_SET = 8'h05;
  // ----------------------------------------
  // reset values and writable bits, indexed by offset
  // ----------------------------------------
  localparam logic [NUM_REGS-1:0][7:0] REG_RST = {8'h01, 8'h00, 8'h00, 8'h00, 8'h40, 8'h40};
  localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {8'h0F, 8'hFF, 8'h01, 8'hFF, 8'h41, 8'h41};
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MODE_EN_BIT = 6;
  localparam int MODE_SEL_BIT = 0;
  localparam int RX_TERM_OFF_BIT = 0;
  localparam int TX_TERM_ON_BIT = 0;
  localparam int TX_CUR_BIT = 1;
  localparam int OUTPUT_PREEMPH_LEVEL_LSB = 2;
  localparam int OUTPUT_PREEMPH_LEVEL_W = 2;
  localparam int CHAN_PER_GRP = 4;
  localparam int NUM_IN_CHAN = 8;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TERM_PULSE_MS = 100;
  localparam int TERM_PULSE_CYC = TERM_PULSE_MS * (CLK_HZ / 1000);
  localparam int UPD_DLY_CYC = 64;
  localparam int CNT_W = 21;
endpackage

/* File: vls_top.sv */
// configuration and control of the two-to-one video link switch
//
// What this block does
// - answer slave address 100100 plus pin bit
// - pulse selected input terminations off after switch
// - term-off bit disconnects all inputs; default connected
// - per-input bit picks 6 or 12 dB
// - one bit sets all output terminations; default on
// - enable bit clear tristates all fast outputs
// - pre-emphasis field decodes to four boost levels
// - select bit routes group A or B whole
// - side select chooses side group independently
// - all four channels handled identically
// - reset pin restores defaults, source A, delay
// - window writes supersede, apply at window end
// - modes registers at 0x00/0x01, reset 0x40
`timescale 1ns/1ps
module vls_top
  import vls_pkg::*;
#(
  parameter int PULSE_CYC = TERM_PULSE_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // pins
  input wire logic cfg_rst_n_i,
  input wire logic addr_pin_i,
  // decoded serial access
  input wire logic [6:0] dev_addr_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [6:0] own_addr_o,
  output logic rd_ack_o,
  output logic [7:0] rd_data_o,
  // fast datapath controls
  output logic [CHAN_PER_GRP-1:0] fast_source_select_o,
  output logic fast_out_hiz_o,
  output logic [NUM_IN_CHAN-1:0] input_term_dis_o,
  output logic [NUM_IN_CHAN-1:0] input_eq_level_o,
  output logic output_term_on_o,
  output logic output_current_level_o,
  output logic [3:0] output_preemph_o,
  // side lines controls
  output logic side_enable_o,
  output logic side_source_select_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic rstn_meta;
  logic rstn_sync;
  logic addr_meta;
  logic addr_sync;
  logic clr;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rstn_meta <= 1'b1;
      rstn_sync <= 1'b1;
    end else begin
      rstn_meta <= cfg_rst_n_i;
      rstn_sync <= rstn_meta;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    addr_meta <= addr_pin_i;
    addr_sync <= addr_meta;
  end

  assign clr = sys_rst_i | ~rstn_sync;

  // ----------------------------------------
  // address match and register file
  // ----------------------------------------
  logic [6:0] own_addr;
  logic hit_wr;
  logic hit_rd;
  logic [NUM_REGS-1:0][7:0] shadow;
  logic [NUM_REGS-1:0][7:0] phys;

  assign own_addr = {SLV_ADDR_HI, addr_sync};
  assign hit_wr = wr_stb_i && (dev_addr_i == own_addr);
  assign hit_rd = rd_stb_i && (dev_addr_i == own_addr);

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    vls_update_gate #(
      .RST_VAL(REG_RST[i]),
      .MASK(REG_MASK[i]),
      .DLY(UPD_DLY_CYC)
    ) u_gate (
      .sys_clk_i(sys_clk_i),
      .clr_i(clr),
      .wr_i(hit_wr && (reg_addr_i == 8'(i))),
      .data_i(wr_data_i),
      .shadow_o(shadow[i]),
      .phys_o(phys[i])
    );
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_ack_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      rd_ack_o <= hit_rd;
      if (hit_rd) begin
        rd_data_o <= (reg_addr_i < 8'(NUM_REGS)) ? shadow[reg_addr_i[2:0]] : 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      own_addr_o <= {SLV_ADDR_HI, 1'b0};
    end else begin
      own_addr_o <= own_addr;
    end
  end

  // ----------------------------------------
  // termination pulse after a source switch
  // ----------------------------------------
  localparam logic [CNT_W-1:0] PULSE_C = CNT_W'(PULSE_CYC);
  logic src_prev;
  logic [CNT_W-1:0] pulse_cnt;
  logic pulse_on;
  logic src_now;

  assign src_now = phys[REG_FAST_MODES][MODE_SEL_BIT];
  assign pulse_on = (pulse_cnt != '0);

  always_ff @(posedge sys_clk_i) begin
    if (clr) begin
      src_prev <= 1'b0;
      pulse_cnt <= '0;
    end else begin
      src_prev <= src_now;
      if (src_now != src_prev) begin
        pulse_cnt <= PULSE_C;
      end else if (pulse_on) begin
        pulse_cnt <= pulse_cnt - CNT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // static control outputs
  // ----------------------------------------
  logic [7:0] tx;
  logic [7:0] fm;
  logic [7:0] sm;

  assign tx = phys[REG_TX_SET];
  assign fm = phys[REG_FAST_MODES];
  assign sm = phys[REG_SIDE_MODES];

  always_ff @(posedge sys_clk_i) begin
    if (clr) begin
      fast_source_select_o <= '0;
      fast_out_hiz_o <= ~REG_RST[REG_FAST_MODES][MODE_EN_BIT];
      input_term_dis_o <= '0;
      input_eq_level_o <= '0;
      output_term_on_o <= REG_RST[REG_TX_SET][TX_TERM_ON_BIT];
      output_current_level_o <= REG_RST[REG_TX_SET][TX_CUR_BIT];
      output_preemph_o <= 4'h1 << REG_RST[REG_TX_SET][OUTPUT_PREEMPH_LEVEL_LSB +: OUTPUT_PREEMPH_LEVEL_W];
      side_enable_o <= REG_RST[REG_SIDE_MODES][MODE_EN_BIT];
      side_source_select_o <= REG_RST[REG_SIDE_MODES][MODE_SEL_BIT];
    end else begin
      fast_source_select_o <= {CHAN_PER_GRP{fm[MODE_SEL_BIT]}};
      fast_out_hiz_o <= ~fm[MODE_EN_BIT];
      input_term_dis_o <= {NUM_IN_CHAN{phys[REG_RX_SET][RX_TERM_OFF_BIT]}}
          | (phys[REG_TERM_PULSE] & {NUM_IN_CHAN{pulse_on}});
      input_eq_level_o <= phys[REG_INPUT_EQ_LEVEL];
      output_term_on_o <= tx[TX_TERM_ON_BIT];
      output_current_level_o <= tx[TX_CUR_BIT];
      output_preemph_o <= 4'h1 << tx[OUTPUT_PREEMPH_LEVEL_LSB +: OUTPUT_PREEMPH_LEVEL_W];
      side_enable_o <= sm[MODE_EN_BIT];
      side_source_select_o <= sm[MODE_SEL_BIT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_ADDR_MATCH: assert property (@(posedge sys_clk_i) disable iff (clr)
      (wr_stb_i && dev_addr_i != own_addr) |=> $stable(shadow))
    else $error("write taken for a foreign slave address");
  AST_PULSE_START: assert property (@(posedge sys_clk_i) disable iff (clr)
      (src_now != src_prev) |=> ##1 (input_term_dis_o == ($past(phys[REG_TERM_PULSE])
      | {NUM_IN_CHAN{$past(phys[REG_RX_SET][RX_TERM_OFF_BIT])}})))
    else $error("termination pulse did not start after switch");
  AST_TERM_OFF: assert property (@(posedge sys_clk_i) disable iff (clr)
      phys[REG_RX_SET][RX_TERM_OFF_BIT] && $stable(phys[REG_RX_SET])
      |=> (input_term_dis_o == 8'hFF))
    else $error("term-off did not disconnect every input");
  AST_EQ_FOLLOW: assert property (@(posedge sys_clk_i) disable iff (clr)
      1'b1 |=> (input_eq_level_o == $past(phys[REG_INPUT_EQ_LEVEL])))
    else $error("equalizer level not following its register");
  AST_TERM_ON: assert property (@(posedge sys_clk_i) disable iff (clr)
      1'b1 |=> (output_term_on_o == $past(tx[TX_TERM_ON_BIT])))
    else $error("output termination not following its bit");
  AST_HIZ: assert property (@(posedge sys_clk_i) disable iff (clr)
      !fm[MODE_EN_BIT] |=> fast_out_hiz_o)
    else $error("outputs not tristated while disabled");
  AST_PREEMPH: assert property (@(posedge sys_clk_i) disable iff (clr)
      1'b1 |=> $onehot(output_preemph_o)
      && output_preemph_o[$past(tx[OUTPUT_PREEMPH_LEVEL_LSB +: OUTPUT_PREEMPH_LEVEL_W])])
    else $error("pre-emphasis decode wrong");
  AST_GROUP: assert property (@(posedge sys_clk_i) disable iff (clr)
      1'b1 |=> (fast_source_select_o == {CHAN_PER_GRP{$past(src_now)}}))
    else $error("channels not routed as one group");
  AST_SIDE: assert property (@(posedge sys_clk_i) disable iff (clr)
      1'b1 |=> (side_source_select_o == $past(sm[MODE_SEL_BIT])))
    else $error("side select wrong");
  AST_RESET_DEF: assert property (@(posedge sys_clk_i)
      clr |=> (shadow[REG_FAST_MODES] == REG_RST[REG_FAST_MODES])
      && (fast_source_select_o == '0))
    else $error("reset did not restore defaults");

  COV_SWITCH: cover property (@(posedge sys_clk_i) disable iff (clr)
      $rose(src_now));
  COV_PULSE_END: cover property (@(posedge sys_clk_i) disable iff (clr)
      $fell(pulse_on));
  COV_WIN_WRITE: cover property (@(posedge sys_clk_i) disable iff (clr)
      hit_wr ##1 hit_wr);
  COV_READ: cover property (@(posedge sys_clk_i) disable iff (clr) hit_rd);
endmodule

/* File: vls_update_gate.sv */
// one register with its update-delay window
`timescale 1ns/1ps
module vls_update_gate
  import vls_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] MASK = 8'hFF,
  parameter int DLY = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic clr_i,
  // write
  input wire logic wr_i,
  input wire logic [7:0] data_i,
  // values
  output logic [7:0] shadow_o,
  output logic [7:0] phys_o
);
  localparam logic [CNT_W-1:0] DLY_C = CNT_W'(DLY);
  localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

  logic [CNT_W-1:0] win_cnt;
  logic [7:0] wr_val;

  assign wr_val = data_i & MASK;

  always_ff @(posedge sys_clk_i) begin
    if (clr_i) begin
      shadow_o <= RST_VAL;
    end else if (wr_i) begin
      shadow_o <= wr_val;
    end
  end

  // window opens on reset and on a write outside it; writes inside do not restart
  always_ff @(posedge sys_clk_i) begin
    if (clr_i) begin
      phys_o <= RST_VAL;
      win_cnt <= DLY_C;
    end else if (win_cnt == '0) begin
      if (wr_i) begin
        phys_o <= wr_val;
        win_cnt <= DLY_C;
      end
    end else if (win_cnt == ONE_C) begin
      phys_o <= wr_i ? wr_val : shadow_o;
      win_cnt <= '0;
    end else begin
      win_cnt <= win_cnt - ONE_C;
    end
  end

  AST_WIN_HOLDS: assert property (@(posedge sys_clk_i) disable iff (clr_i)
      (win_cnt > ONE_C) |=> $stable(phys_o))
    else $error("physical value changed inside update window");
  AST_IDLE_APPLY: assert property (@(posedge sys_clk_i) disable iff (clr_i)
      (win_cnt == '0 && wr_i) |=> (phys_o == $past(wr_val)) && (win_cnt == DLY_C))
    else $error("write after window did not apply at once");
endmodule
